// file: src/prsd_pkg.sv
package prsd_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int RDIV_W = 14;
    localparam int LOSS_W = 8;

    localparam logic [ADDR_W-1:0] OFS_CP = 10'h010;
    localparam logic [ADDR_W-1:0] OFS_RDIV_LO = 10'h011;
    localparam logic [ADDR_W-1:0] OFS_RDIV_HI = 10'h012;
    localparam logic [ADDR_W-1:0] OFS_ABL = 10'h017;
    localparam logic [ADDR_W-1:0] OFS_MONCFG = 10'h01b;
    localparam logic [ADDR_W-1:0] OFS_REFCTL = 10'h01c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 10'h01d;
    localparam logic [ADDR_W-1:0] OFS_CNTRST = 10'h01e;
    localparam logic [ADDR_W-1:0] OFS_UPDATE = 10'h232;

    localparam logic [DATA_W-1:0] UPDATE_GO = 8'h01;
    localparam logic [DATA_W-1:0] RDIV_HI_MASK = 8'h3f;
    localparam logic [1:0] PLL_ON = 2'h0;
    localparam logic [1:0] PLL_OFF = 2'h1;
    localparam logic [3:0] MON_PRI_BAD = 4'h7;
    localparam logic [3:0] MON_SEC_BAD = 4'h6;
    localparam logic [3:0] STS_PRI_BAD = 4'hf;
    localparam logic [3:0] STS_SEC_BAD = 4'he;

    localparam int CLK_NS = 10;
    localparam int REF_LOSS_NS = 1000;
    localparam int REF_LOSS_CYC = (REF_LOSS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [LOSS_W-1:0] LOSS_MAX = LOSS_W'(REF_LOSS_CYC);

    localparam int PIN_PRI = 0;
    localparam int PIN_SEC = 1;
    localparam int PIN_SEL = 2;
    localparam int PIN_SYNC = 3;
    localparam int PIN_N = 4;

    typedef enum logic [2:0] {
        CPM_HIZ = 3'h0,
        CPM_UP = 3'h1,
        CPM_DOWN = 3'h2,
        CPM_NORMAL = 3'h3
    } prsd_cpm_t;

    typedef enum logic [3:0] {
        SW_PRI = 4'b0001,
        SW_SEC = 4'b0010,
        SW_TO_PRI = 4'b0100,
        SW_TO_SEC = 4'b1000
    } prsd_sw_t;

    typedef struct packed {
        logic pfd_neg;
        prsd_cpm_t mode;
        logic [1:0] rsvd;
        logic [1:0] pll_pd;
    } prsd_cp_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic [2:0] cp_cur;
        logic [1:0] abl;
    } prsd_abl_t;

    typedef struct packed {
        logic [3:0] sts_src;
        logic [3:0] mon_src;
    } prsd_mon_t;

    typedef struct packed {
        logic deglitch_off;
        logic manual_sec;
        logic auto_en;
        logic selpin_en;
        logic prefer_sec;
        logic sec_en;
        logic pri_en;
        logic diff_sel;
    } prsd_refc_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic sync_en;
        logic status_cmd;
        logic shared_rst;
        logic r_rst;
    } prsd_cnt_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic diff_on;
        logic pending;
        logic sec_valid;
        logic pri_valid;
        logic sel_sec;
    } prsd_sts_t;

    typedef struct packed {
        prsd_cp_t cp;
        logic [DATA_W-1:0] rdiv_lo;
        logic [DATA_W-1:0] rdiv_hi;
        prsd_abl_t abl;
        prsd_mon_t mon;
        prsd_refc_t refc;
        prsd_cnt_t cnt;
    } prsd_cfg_t;

    typedef struct packed {
        logic hiz;
        logic up;
        logic down;
        logic normal;
        logic [2:0] cur_step;
        logic [1:0] abl_width;
    } prsd_cp_ctl_t;

    typedef struct packed {
        logic diff;
        logic pri;
        logic sec;
    } prsd_buf_pd_t;

    localparam prsd_cp_t CP_RST = '{pfd_neg: 1'b0, mode: CPM_HIZ, rsvd: 2'h0, pll_pd: PLL_OFF};
    localparam prsd_cfg_t CFG_RST = '{cp: CP_RST, default: '0};
    localparam prsd_cp_ctl_t CP_CTL_RST = '{hiz: 1'b1, default: '0};
    localparam prsd_buf_pd_t BUF_PD_RST = '{default: 1'b1};
endpackage

// file: src/prsd_top.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module prsd_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire logic [prsd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [prsd_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [prsd_pkg::DATA_W-1:0] reg_rd_data,
    // reference and control pins
    input wire logic primary_reference,
    input wire logic secondary_reference,
    input wire logic ref_select_pin,
    input wire logic sync_n,
    // pins and loop controls
    output logic reference_monitor_pin,
    output logic status_pin,
    output logic pfd_ref_pulse,
    output prsd_pkg::prsd_cp_ctl_t cp_ctl,
    output prsd_pkg::prsd_buf_pd_t buf_pd
);
    import prsd_pkg::*;

    typedef struct packed {
        prsd_cfg_t sh;
        prsd_cfg_t act;
        logic [DATA_W-1:0] rd_data;
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic [PIN_SEC:PIN_PRI] s3;
        logic [LOSS_W-1:0] pri_loss;
        logic [LOSS_W-1:0] sec_loss;
        logic pri_valid;
        logic sec_valid;
        prsd_sw_t sw;
        logic [RDIV_W-1:0] div_cnt;
        logic pfd_pulse;
        logic mon_pin;
        logic sts_pin;
        prsd_cp_ctl_t cp_ctl;
        prsd_buf_pd_t buf_pd;
    } prsd_state_t;

    localparam prsd_state_t ST_RST = '{
        sh: CFG_RST,
        act: CFG_RST,
        sw: SW_PRI,
        cp_ctl: CP_CTL_RST,
        buf_pd: BUF_PD_RST,
        default: '0
    };

    prsd_state_t st_ff;
    prsd_state_t nxt_st;

    function automatic logic rise(input logic now, input logic was);
        return now & ~was;
    endfunction

    // saturates so a missing clock reads as lost, not wrapped
    function automatic logic [LOSS_W-1:0] loss_next(
        input logic edge_seen,
        input logic [LOSS_W-1:0] cnt
    );
        if (edge_seen) begin
            return '0;
        end
        if (cnt == LOSS_MAX) begin
            return cnt;
        end
        return LOSS_W'(cnt + 1'b1);
    endfunction

    function automatic logic src_level(
        input logic [3:0] src,
        input logic [3:0] pri_code,
        input logic [3:0] sec_code,
        input logic pv,
        input logic sv
    );
        if (src == pri_code) begin
            return ~pv;
        end
        if (src == sec_code) begin
            return ~sv;
        end
        return 1'b0;
    endfunction

    logic pll_down;
    logic pri_edge;
    logic sec_edge;
    logic cmd_lvl;
    logic want_sec;
    logic div_rst;
    logic upd_wr;
    logic sel_edge;
    logic [RDIV_W-1:0] ratio;
    logic [RDIV_W-1:0] last_cnt;
    prsd_sts_t sts;

    assign pll_down = st_ff.act.cp.pll_pd != PLL_ON;
    assign pri_edge = rise(st_ff.s2[PIN_PRI], st_ff.s3[PIN_PRI])
        & ~(st_ff.buf_pd.pri & st_ff.buf_pd.diff);
    assign sec_edge = rise(st_ff.s2[PIN_SEC], st_ff.s3[PIN_SEC])
        & ~st_ff.buf_pd.sec;
    assign upd_wr = reg_wr && reg_addr == OFS_UPDATE && reg_wr_data == UPDATE_GO;

    assign cmd_lvl = st_ff.act.cnt.status_cmd ? st_ff.sts_pin : st_ff.mon_pin;

    // switch target; auto mode only follows the pin level, so it always reverts
    always_comb begin
        want_sec = 1'b0;
        if (st_ff.act.refc.diff_sel) begin
            want_sec = 1'b0;
        end else if (st_ff.act.refc.auto_en) begin
            want_sec = st_ff.act.refc.prefer_sec ? ~cmd_lvl : cmd_lvl;
        end else if (st_ff.act.refc.selpin_en) begin
            want_sec = st_ff.s2[PIN_SEL];
        end else begin
            want_sec = st_ff.act.refc.manual_sec;
        end
    end

    assign div_rst = st_ff.act.cnt.r_rst
        | st_ff.act.cnt.shared_rst
        | (st_ff.act.cnt.sync_en & ~st_ff.s2[PIN_SYNC]);

    assign ratio = {st_ff.act.rdiv_hi[RDIV_W-DATA_W-1:0], st_ff.act.rdiv_lo};
    assign last_cnt = (ratio <= RDIV_W'(1)) ? '0 : RDIV_W'(ratio - 1'b1);

    always_comb begin
        sts = '0;
        sts.sel_sec = st_ff.sw == SW_SEC;
        sts.pri_valid = st_ff.pri_valid;
        sts.sec_valid = st_ff.sec_valid;
        sts.pending = st_ff.sw == SW_TO_PRI || st_ff.sw == SW_TO_SEC;
        sts.diff_on = ~st_ff.buf_pd.diff;
    end

    always_comb begin
        nxt_st = st_ff;
        sel_edge = 1'b0;

        nxt_st.s1 = {sync_n, ref_select_pin, secondary_reference, primary_reference};
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2[PIN_SEC:PIN_PRI];

        // shadow registers
        if (reg_wr) begin
            case (reg_addr)
                OFS_CP: begin
                    nxt_st.sh.cp = prsd_cp_t'(reg_wr_data);
                end
                OFS_RDIV_LO: begin
                    nxt_st.sh.rdiv_lo = reg_wr_data;
                end
                OFS_RDIV_HI: begin
                    nxt_st.sh.rdiv_hi = reg_wr_data & RDIV_HI_MASK;
                end
                OFS_ABL: begin
                    nxt_st.sh.abl = prsd_abl_t'(reg_wr_data);
                end
                OFS_MONCFG: begin
                    nxt_st.sh.mon = prsd_mon_t'(reg_wr_data);
                end
                OFS_REFCTL: begin
                    nxt_st.sh.refc = prsd_refc_t'(reg_wr_data);
                end
                OFS_CNTRST: begin
                    nxt_st.sh.cnt = prsd_cnt_t'(reg_wr_data);
                end
                default: begin
                end
            endcase
        end
        if (upd_wr) begin
            nxt_st.act = st_ff.sh;
        end

        // read data stands in the following cycle only
        nxt_st.rd_data = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CP: begin
                    nxt_st.rd_data = st_ff.sh.cp;
                end
                OFS_RDIV_LO: begin
                    nxt_st.rd_data = st_ff.sh.rdiv_lo;
                end
                OFS_RDIV_HI: begin
                    nxt_st.rd_data = st_ff.sh.rdiv_hi;
                end
                OFS_ABL: begin
                    nxt_st.rd_data = st_ff.sh.abl;
                end
                OFS_MONCFG: begin
                    nxt_st.rd_data = st_ff.sh.mon;
                end
                OFS_REFCTL: begin
                    nxt_st.rd_data = st_ff.sh.refc;
                end
                OFS_STATUS: begin
                    nxt_st.rd_data = sts;
                end
                OFS_CNTRST: begin
                    nxt_st.rd_data = st_ff.sh.cnt;
                end
                default: begin
                    nxt_st.rd_data = '0;
                end
            endcase
        end

        // reference presence; a powered-down buffer never counts as valid
        nxt_st.pri_loss = loss_next(pri_edge, st_ff.pri_loss);
        nxt_st.sec_loss = loss_next(sec_edge, st_ff.sec_loss);
        nxt_st.pri_valid = (~st_ff.buf_pd.pri | ~st_ff.buf_pd.diff)
            & (nxt_st.pri_loss != LOSS_MAX);
        nxt_st.sec_valid = ~st_ff.buf_pd.sec & (nxt_st.sec_loss != LOSS_MAX);

        nxt_st.mon_pin = src_level(st_ff.act.mon.mon_src, MON_PRI_BAD, MON_SEC_BAD,
            st_ff.pri_valid, st_ff.sec_valid);
        nxt_st.sts_pin = src_level(st_ff.act.mon.sts_src, STS_PRI_BAD, STS_SEC_BAD,
            st_ff.pri_valid, st_ff.sec_valid);

        // switchover; waiting states hold off edges until the new reference rises
        unique case (st_ff.sw)
            SW_PRI: begin
                sel_edge = pri_edge;
                if (want_sec) begin
                    nxt_st.sw = st_ff.act.refc.deglitch_off ? SW_SEC : SW_TO_SEC;
                end
            end
            SW_SEC: begin
                sel_edge = sec_edge;
                if (!want_sec) begin
                    nxt_st.sw = st_ff.act.refc.deglitch_off ? SW_PRI : SW_TO_PRI;
                end
            end
            SW_TO_SEC: begin
                if (!want_sec) begin
                    nxt_st.sw = SW_PRI;
                end else if (sec_edge) begin
                    sel_edge = 1'b1;
                    nxt_st.sw = SW_SEC;
                end
            end
            SW_TO_PRI: begin
                if (want_sec) begin
                    nxt_st.sw = SW_SEC;
                end else if (pri_edge) begin
                    sel_edge = 1'b1;
                    nxt_st.sw = SW_PRI;
                end
            end
            default: begin
                nxt_st.sw = SW_PRI;
            end
        endcase

        // reference divider, pulse marks the phase detector reference edge
        nxt_st.pfd_pulse = 1'b0;
        if (div_rst) begin
            nxt_st.div_cnt = '0;
        end else if (sel_edge && st_ff.div_cnt >= last_cnt) begin
            nxt_st.div_cnt = '0;
            nxt_st.pfd_pulse = 1'b1;
        end else if (sel_edge) begin
            nxt_st.div_cnt = RDIV_W'(st_ff.div_cnt + 1'b1);
        end

        // buffer power-down
        nxt_st.buf_pd.diff = pll_down | ~st_ff.act.refc.diff_sel
            | ~st_ff.act.refc.pri_en;
        nxt_st.buf_pd.pri = pll_down | ~st_ff.act.refc.pri_en
            | st_ff.act.refc.diff_sel;
        nxt_st.buf_pd.sec = pll_down | ~st_ff.act.refc.sec_en
            | st_ff.act.refc.diff_sel;

        // pump controls; undefined mode codes fall back to high-z
        nxt_st.cp_ctl = '0;
        nxt_st.cp_ctl.abl_width = st_ff.act.abl.abl;
        nxt_st.cp_ctl.cur_step = st_ff.act.abl.cp_cur;
        case (st_ff.act.cp.mode)
            CPM_NORMAL: begin
                nxt_st.cp_ctl.normal = 1'b1;
            end
            CPM_UP: begin
                nxt_st.cp_ctl.up = 1'b1;
            end
            CPM_DOWN: begin
                nxt_st.cp_ctl.down = 1'b1;
            end
            default: begin
                nxt_st.cp_ctl.hiz = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rd_data = st_ff.rd_data;
    assign reference_monitor_pin = st_ff.mon_pin;
    assign status_pin = st_ff.sts_pin;
    assign pfd_ref_pulse = st_ff.pfd_pulse;
    assign cp_ctl = st_ff.cp_ctl;
    assign buf_pd = st_ff.buf_pd;

    abl_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        $changed(st_ff.act.abl.abl) |=> cp_ctl.abl_width == $past(st_ff.act.abl.abl))
        else $error("antibacklash width not applied");

    cp_normal_a: assert property (@(posedge clk_sys) disable iff (reset)
        st_ff.act.cp.mode == CPM_NORMAL |=> cp_ctl.normal && !cp_ctl.hiz && !cp_ctl.up)
        else $error("pump not in normal mode");

    diff_pd_a: assert property (@(posedge clk_sys) disable iff (reset)
        (pll_down || !st_ff.act.refc.diff_sel) |=> buf_pd.diff)
        else $error("differential buffer left powered");

    se_pd_a: assert property (@(posedge clk_sys) disable iff (reset)
        (pll_down || st_ff.act.refc.diff_sel || !st_ff.act.refc.sec_en) |=> buf_pd.sec)
        else $error("secondary buffer left powered");

    diff_no_sw_a: assert property (@(posedge clk_sys) disable iff (reset)
        st_ff.act.refc.diff_sel && st_ff.sw == SW_PRI |=> st_ff.sw == SW_PRI)
        else $error("switch in differential mode");

    mon_high_a: assert property (@(posedge clk_sys) disable iff (reset)
        st_ff.act.mon.mon_src == MON_PRI_BAD && !st_ff.pri_valid
        ##1 st_ff.act.mon.mon_src == MON_PRI_BAD |-> reference_monitor_pin)
        else $error("monitor pin low with primary invalid");

    deglitch_a: assert property (@(posedge clk_sys) disable iff (reset)
        st_ff.sw == SW_TO_SEC && !sec_edge && !div_rst |=> $stable(st_ff.div_cnt))
        else $error("edge passed while switch pending");

    div_one_a: assert property (@(posedge clk_sys) disable iff (reset)
        sel_edge && !div_rst && ratio <= RDIV_W'(1) |=> pfd_ref_pulse)
        else $error("ratio one did not pulse every edge");

    div_wrap_a: assert property (@(posedge clk_sys) disable iff (reset)
        pfd_ref_pulse |-> st_ff.div_cnt == '0 && $past(st_ff.div_cnt) >= $past(last_cnt))
        else $error("divider pulsed before its count");

    div_rst_a: assert property (@(posedge clk_sys) disable iff (reset)
        div_rst |=> st_ff.div_cnt == '0 && !pfd_ref_pulse)
        else $error("divider ran while held in reset");

    rst_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
        st_ff.sh.cnt.r_rst && !(reg_wr && reg_addr == OFS_CNTRST) |=> st_ff.sh.cnt.r_rst)
        else $error("reset bit cleared itself");

    upd_only_a: assert property (@(posedge clk_sys) disable iff (reset)
        !upd_wr |=> $stable(st_ff.act))
        else $error("settings changed without update");
endmodule

// file: verif/prsd_ref_src.sv
`timescale 1ns/1ps
module prsd_ref_src #(
    parameter int PRI_HALF = 40,
    parameter int SEC_HALF = 60
) (
    // run controls
    input wire logic pri_on,
    input wire logic sec_on,
    // reference pins
    output logic primary_reference,
    output logic secondary_reference
);
    // a stopped source parks low, as a dc-coupled cmos driver does
    initial begin
        primary_reference = 1'b0;
        #3;
        forever begin
            #(PRI_HALF);
            primary_reference = pri_on ? ~primary_reference : 1'b0;
        end
    end

    // odd offset keeps the two sources apart from each other
    initial begin
        secondary_reference = 1'b0;
        #7;
        forever begin
            #(SEC_HALF);
            secondary_reference = sec_on ? ~secondary_reference : 1'b0;
        end
    end
endmodule

// file: verif/prsd_top_tb.sv
`timescale 1ns/1ps
module prsd_top_tb;
    import prsd_pkg::*;
    localparam int LIMIT = 40000;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wr_data = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rd_data;
    logic primary_reference;
    logic secondary_reference;
    logic ref_select_pin = 1'b0;
    logic sync_n = 1'b1;
    logic pri_on = 1'b1;
    logic sec_on = 1'b1;
    logic reference_monitor_pin;
    logic status_pin;
    logic pfd_ref_pulse;
    prsd_cp_ctl_t cp_ctl;
    prsd_buf_pd_t buf_pd;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #5 clk_sys = ~clk_sys;

    prsd_ref_src src (
        .pri_on(pri_on),
        .sec_on(sec_on),
        .primary_reference(primary_reference),
        .secondary_reference(secondary_reference)
    );

    prsd_top dut (
        .clk_sys(clk_sys),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data),
        .primary_reference(primary_reference),
        .secondary_reference(secondary_reference),
        .ref_select_pin(ref_select_pin),
        .sync_n(sync_n),
        .reference_monitor_pin(reference_monitor_pin),
        .status_pin(status_pin),
        .pfd_ref_pulse(pfd_ref_pulse),
        .cp_ctl(cp_ctl),
        .buf_pd(buf_pd)
    );

    task automatic end_of_test;
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // idle edge after each strobe so no signal is driven twice in one step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rc(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] d;
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rd_data;
        chk(16'(d & m), 16'(exp), "read");
    endtask

    task automatic upd;
        wr(OFS_UPDATE, 8'h01);
        settle(2);
    endtask

    task automatic quiet(input int n);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (pfd_ref_pulse === 1'b1) c++;
        end
        chk(16'(c), 16'h0, "pulses");
    endtask

    // spacing between two consecutive divider pulses, in clocks
    task automatic gap(input int exp);
        int n;
        int w;
        n = 0;
        w = 0;
        while (pfd_ref_pulse !== 1'b1 && w < 5000) begin
            settle(1);
            w++;
        end
        settle(1);
        while (pfd_ref_pulse !== 1'b1 && n < 5000) begin
            settle(1);
            n++;
        end
        chk(16'(n + 1), 16'(exp), "gap");
    endtask

    task automatic wait_mon(input logic exp, input int max);
        int w;
        w = 0;
        while (reference_monitor_pin !== exp && w < max) begin
            settle(1);
            w++;
        end
        chk(16'(reference_monitor_pin), 16'(exp), "monitor");
        chk(16'(status_pin), 16'(exp), "status pin");
    endtask

    task automatic t_reset;
        chk(16'(buf_pd), 16'h7, "buf pd");
        chk(16'(cp_ctl), 16'h100, "pump");
        rc(OFS_CP, 8'h01, 8'hff);
        rc(OFS_REFCTL, 8'h00, 8'hff);
        quiet(20);
        wr(10'h020, 8'hff);
        rc(10'h020, 8'h00, 8'hff);
    endtask

    task automatic t_pump;
        wr(OFS_CP, 8'h30);
        settle(3);
        chk(16'(cp_ctl.hiz), 16'h1, "early");
        rc(OFS_CP, 8'h30, 8'hff);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CP, {1'b0, 3'(m), 4'h0});
            wr(OFS_ABL, {3'h0, 3'(2 * m + 1), 2'(m)});
            upd();
            chk(16'({cp_ctl.hiz, cp_ctl.up, cp_ctl.down, cp_ctl.normal}),
                16'(4'h8 >> m), "mode");
            chk(16'({cp_ctl.cur_step, cp_ctl.abl_width}),
                16'({3'(2 * m + 1), 2'(m)}), "step");
        end
    endtask

    task automatic t_buf;
        logic [7:0] cp [6] = '{8'h30, 8'h30, 8'h30, 8'h31, 8'h30, 8'h30};
        logic [7:0] rv [6] = '{8'h03, 8'h06, 8'h02, 8'h06, 8'h07, 8'h01};
        logic [2:0] ex [6] = '{3'h3, 3'h4, 3'h5, 3'h7, 3'h3, 3'h7};
        for (int i = 0; i < 6; i++) begin
            wr(OFS_CP, cp[i]);
            wr(OFS_REFCTL, rv[i]);
            upd();
            chk(16'(buf_pd), 16'(ex[i]), "buffers");
        end
    endtask

    // ascending ratios so a running count never overshoots the new one
    task automatic t_div;
        logic [7:0] lo [4] = '{8'h00, 8'h01, 8'h03, 8'h00};
        logic [7:0] hi [4] = '{8'h00, 8'h00, 8'h00, 8'hc1};
        int ex [4] = '{8, 8, 24, 2048};
        wr(OFS_REFCTL, 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_RDIV_LO, lo[i]);
            wr(OFS_RDIV_HI, hi[i]);
            upd();
            gap(ex[i]);
        end
        rc(OFS_RDIV_HI, 8'h01, 8'hff);
    endtask

    task automatic t_rst;
        logic [7:0] b [3] = '{8'h01, 8'h02, 8'h08};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            sync_n <= (i != 2);
            wr(OFS_CNTRST, b[i]);
            wr(OFS_RDIV_HI, 8'h00);
            wr(OFS_RDIV_LO, 8'h02);
            upd();
            quiet(200);
            rc(OFS_CNTRST, b[i], 8'hff);
            wr(OFS_CNTRST, 8'h00);
            sync_n <= 1'b1;
            upd();
            gap(16);
        end
    endtask

    task automatic t_auto;
        wr(OFS_MONCFG, 8'hf7);
        wr(OFS_REFCTL, 8'h26);
        upd();
        wait_mon(1'b0, 300);
        @(posedge clk_sys);
        pri_on <= 1'b0;
        wait_mon(1'b1, 300);
        settle(40);
        rc(OFS_STATUS, 8'h05, 8'h1f);
        @(posedge clk_sys);
        pri_on <= 1'b1;
        wait_mon(1'b0, 300);
        settle(40);
        rc(OFS_STATUS, 8'h06, 8'h1f);
        // status pin commands, secondary preferred, deglitch off
        wr(OFS_MONCFG, 8'he6);
        wr(OFS_CNTRST, 8'h04);
        wr(OFS_REFCTL, 8'hae);
        upd();
        rc(OFS_STATUS, 8'h07, 8'h0f);
        @(posedge clk_sys);
        sec_on <= 1'b0;
        wait_mon(1'b1, 300);
        rc(OFS_STATUS, 8'h02, 8'h0f);
        @(posedge clk_sys);
        sec_on <= 1'b1;
        wait_mon(1'b0, 300);
    endtask

    task automatic t_man;
        wr(OFS_REFCTL, 8'h46);
        upd();
        settle(40);
        rc(OFS_STATUS, 8'h07, 8'h1f);
        wr(OFS_REFCTL, 8'h16);
        upd();
        settle(40);
        rc(OFS_STATUS, 8'h06, 8'h1f);
        @(posedge clk_sys);
        ref_select_pin <= 1'b1;
        settle(40);
        rc(OFS_STATUS, 8'h07, 8'h1f);
        @(posedge clk_sys);
        ref_select_pin <= 1'b0;
        sec_on <= 1'b0;
        settle(150);
        wr(OFS_REFCTL, 8'h46);
        upd();
        quiet(100);
        rc(OFS_STATUS, 8'h08, 8'h08);
        @(posedge clk_sys);
        sec_on <= 1'b1;
        gap(24);
        @(posedge clk_sys);
        ref_select_pin <= 1'b1;
        wr(OFS_REFCTL, 8'h53);
        upd();
        settle(40);
        rc(OFS_STATUS, 8'h10, 8'h11);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        settle(1);
        t_reset();
        t_pump();
        t_buf();
        t_div();
        t_rst();
        t_auto();
        t_man();
        end_of_test();
    end

    // hang guard, well above the expected length of the run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            end_of_test();
        end
    end
endmodule
